// [testbench/test_adc_scan_status_flags.sv]
`timescale 1ns/10ps
module test_adc_scan_status_flags
  import adcsf_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam adcsf_scan_t EV_START = 3'h4;
  localparam adcsf_scan_t EV_ITER = 3'h2;
  localparam adcsf_scan_t EV_IDLE = 3'h1;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr;
  adcsf_scan_t scan_a_i, scan_b_i;
  adcsf_conv_t conv_i;
  logic start_grant_a_o, start_grant_b_o;
  logic [7:0] slot_enable_o, result_read_i;
  logic irq_done_o, irq_zc_o, irq_under_o, irq_over_o;
  int err_count, total_checks;
  logic [4:0] m_ctrl [7] = '{5'h0, 5'h0, 5'h3, 5'h3, 5'h1, 5'h1, 5'h0};
  logic [7:0] m_dis [7] = '{8'h20, 8'h01, 8'h20, 8'h02, 8'h02, 8'h40, 8'h0};
  logic [7:0] m_exp [7] = '{8'h1f, 8'h00, 8'h11, 8'h11, 8'hf1, 8'h3f, 8'hff};

  adcsf_top #(.AW(24)) u_adcsf_top (
    .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_a_i(scan_a_i),
    .scan_b_i(scan_b_i), .start_grant_a_o(start_grant_a_o),
    .start_grant_b_o(start_grant_b_o), .slot_enable_o(slot_enable_o),
    .conv_i(conv_i), .result_read_i(result_read_i),
    .irq_done_o(irq_done_o), .irq_zc_o(irq_zc_o),
    .irq_under_o(irq_under_o), .irq_over_o(irq_over_o)
  );

  always #10 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [21:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      tally_and_finish();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [21:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic scan_ev(input logic b, input adcsf_scan_t ev);
    @(posedge clk_i);
    if (b) begin
      scan_b_i <= ev;
    end else begin
      scan_a_i <= ev;
    end
    @(posedge clk_i);
    scan_a_i <= '0;
    scan_b_i <= '0;
    @(negedge clk_i);
  endtask

  task automatic conv(input logic [2:0] s, input logic [15:0] raw,
                      input logic [15:0] corr, input logic [15:0] fl,
                      input logic [15:0] ce);
    @(posedge clk_i);
    conv_i <= {1'b1, s, raw, corr, fl, ce};
    @(posedge clk_i);
    conv_i <= '0;
  endtask

  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("CHECK FAILED at %0t: run too long", $time);
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    scan_a_i = '0;
    scan_b_i = '0;
    conv_i = '0;
    result_read_i = '0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(STATUS_IDX, 32'h0);
    rd(SAMPLE_SLOT_DISABLE_IDX, 32'h0);
    rd(ZSTS_IDX, 32'h0);
    chk({24'h0, slot_enable_o}, 32'hff);
    apb(1'b1, SAMPLE_SLOT_DISABLE_IDX, 32'hffff_ff20);
    rd(SAMPLE_SLOT_DISABLE_IDX, 32'h20);
    // unmapped place: refused, nothing written
    apb(1'b1, 22'h190001, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h1);
    // enabled slots for each mode and disable pattern
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, CTRL_IDX, {27'h0, m_ctrl[i]});
      apb(1'b1, SAMPLE_SLOT_DISABLE_IDX, {24'h0, m_dis[i]});
      settle();
      chk({24'h0, slot_enable_o}, {24'h0, m_exp[i]});
    end
    // sequential scan on converter a
    scan_ev(1'b0, EV_START);
    chk({31'h0, start_grant_a_o}, 32'h1);
    rd(STATUS_IDX, 32'h8000);
    scan_ev(1'b0, EV_START);
    chk({31'h0, start_grant_a_o}, 32'h0);
    scan_ev(1'b0, EV_ITER);
    rd(STATUS_IDX, 32'h8800);
    apb(1'b1, STATUS_IDX, 32'h0);
    rd(STATUS_IDX, 32'h8800);
    apb(1'b1, STATUS_IDX, 32'h0800);
    rd(STATUS_IDX, 32'h8000);
    scan_ev(1'b0, EV_ITER);
    rd(STATUS_IDX, 32'h8800);
    chk({31'h0, irq_done_o}, 32'h1);
    // writing one to a clear done flag must not set it
    apb(1'b1, STATUS_IDX, 32'h3800);
    rd(STATUS_IDX, 32'h8000);
    scan_ev(1'b0, EV_IDLE);
    rd(STATUS_IDX, 32'h0);
    // independent parallel, converter b
    apb(1'b1, CTRL_IDX, 32'h1);
    scan_ev(1'b1, EV_START);
    chk({31'h0, start_grant_b_o}, 32'h1);
    rd(STATUS_IDX, 32'h4000);
    scan_ev(1'b1, EV_ITER);
    rd(STATUS_IDX, 32'h5000);
    scan_ev(1'b1, EV_IDLE);
    apb(1'b1, STATUS_IDX, 32'h1000);
    rd(STATUS_IDX, 32'h0);
    // bound checks, interrupts masked first
    apb(1'b1, CTRL_IDX, 32'h0);
    conv(3'h2, 16'h0800, 16'h0, 16'h1000, CEIL_OFF);
    conv(3'h3, 16'h8000, 16'h0, FLOOR_OFF, CEIL_OFF);
    conv(3'h5, 16'h7fff, 16'h0, FLOOR_OFF, CEIL_OFF);
    conv(3'h6, 16'h2000, 16'h0, FLOOR_OFF, 16'h1000);
    rd(BOUND_IDX, 32'h4004);
    rd(STATUS_IDX, 32'h036c);
    chk({31'h0, irq_under_o}, 32'h0);
    apb(1'b1, CTRL_IDX, 32'h0c);
    settle();
    chk({30'h0, irq_under_o, irq_over_o}, 32'h3);
    // an in-range result leaves the latched bit alone
    conv(3'h2, 16'h1000, 16'h0, 16'h1000, CEIL_OFF);
    apb(1'b1, BOUND_IDX, 32'h0);
    rd(BOUND_IDX, 32'h4004);
    apb(1'b1, BOUND_IDX, 32'h0004);
    rd(STATUS_IDX, 32'h016c);
    apb(1'b1, BOUND_IDX, 32'h4000);
    rd(STATUS_IDX, 32'h006c);
    @(posedge clk_i);
    result_read_i <= 8'h25;
    @(posedge clk_i);
    result_read_i <= 8'h0;
    rd(STATUS_IDX, 32'h0048);
    // sign change: slot0 any, slot1 pos-neg, slot2 neg-pos, slot3 off
    apb(1'b1, ZSEL_IDX, 32'h27);
    apb(1'b1, CTRL_IDX, 32'h10);
    for (int s = 0; s < 4; s++) begin
      conv(3'(s), 16'h0, 16'h8000, FLOOR_OFF, CEIL_OFF);
    end
    rd(ZSTS_IDX, 32'h3);
    rd(STATUS_IDX, 32'h044f);
    for (int s = 0; s < 4; s++) begin
      conv(3'(s), 16'h0, 16'h0100, FLOOR_OFF, CEIL_OFF);
    end
    rd(ZSTS_IDX, 32'h7);
    chk({31'h0, irq_zc_o}, 32'h1);
    apb(1'b1, ZSTS_IDX, 32'hffff_0003);
    rd(ZSTS_IDX, 32'h4);
    rd(STATUS_IDX, 32'h044f);
    apb(1'b1, ZSTS_IDX, 32'h4);
    rd(STATUS_IDX, 32'h004f);
    settle();
    chk({31'h0, irq_zc_o}, 32'h0);
    tally_and_finish();
  end
endmodule

// [verilog/adcsf_pkg.sv]
// Notes on behaviour
// - reset leaves all slot disable bits clear
// - sequential scan stops before a disabled slot
// - a disable bit blocks later slots too
// - paired scan, slot one or five leaves 0,4
// - reserved bits read zero, ignore writes
// - status flags sticky except scan active bits
// - starts ignored while scan active
// - active a tracks sequential/paired, b independent
// - done a for scans, done b converter b
// - each loop iteration sets done flag again
// - done flags clear only by writing one
// - sign change flag sets per conversion, w1c clear
// - floor checked only when floor nonzero
// - ceiling checked only when not disable value
// - summary bound flags clear when all cleared
// - slot bits latch ceiling and floor violations
// - bound status bits sticky, one clears
// - sign change bit follows slot direction select
// - sign change status bits sticky, one clears
// - disabled select never sets sign change bit
// - ready sets on store, clears on read
// - select 00 off 01 pos-neg 10 neg-pos 11 any
package adcsf_pkg;
  // ----------------------------------------
  // register indices, byte address is 4x
  // ----------------------------------------
  localparam logic [21:0] CTRL_IDX = 22'h190000;
  localparam logic [21:0] ZSEL_IDX = 22'h190003;
  localparam logic [21:0] SAMPLE_SLOT_DISABLE_IDX = 22'h190005;
  localparam logic [21:0] STATUS_IDX = 22'h190006;
  localparam logic [21:0] BOUND_IDX = 22'h190007;
  localparam logic [21:0] ZSTS_IDX = 22'h190008;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CTRL_PAR = 0;
  localparam int CTRL_PAIRED = 1;
  localparam int CTRL_UIE = 2;
  localparam int CTRL_OIE = 3;
  localparam int CTRL_ZIE = 4;
  localparam logic [4:0] CTRL_RST = 5'h02;
  localparam logic [7:0] SAMPLE_SLOT_DISABLE_RST = 8'h00;
  localparam logic [15:0] ZSEL_RST = 16'h0000;
  localparam int ST_ACT_A = 15;
  localparam int ST_ACT_B = 14;
  localparam int ST_DONE_B = 12;
  localparam int ST_DONE_A = 11;
  localparam int ST_ZC = 10;
  localparam int ST_UNDER = 9;
  localparam int ST_OVER = 8;
  localparam logic [15:0] FLOOR_OFF = 16'h0000;
  localparam logic [15:0] CEIL_OFF = 16'h7ff8;
  localparam logic [1:0] ZSEL_POS_NEG = 2'h1;
  localparam logic [1:0] ZSEL_NEG_POS = 2'h2;
  localparam logic [1:0] ZSEL_ANY = 2'h3;
  // one finished conversion from the core
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [15:0] raw;
    logic [15:0] corrected;
    logic [15:0] floor;
    logic [15:0] ceiling;
  } adcsf_conv_t;
  // scan sequencer events for one converter
  typedef struct packed {
    logic start;
    logic iter_done;
    logic idle;
  } adcsf_scan_t;
endpackage

// [verilog/adcsf_slot_mask.sv]
`timescale 1ns/10ps
module adcsf_slot_mask
  import adcsf_pkg::*;
(
  // configuration
  input wire logic [7:0] disable_i,
  input wire logic parallel_i,
  input wire logic paired_i,
  // enabled slots
  output logic [7:0] enable_o
);
  logic [7:0] seq_en;
  logic [7:0] ind_en;
  logic [7:0] par_en;
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_seq
      assign seq_en[k] = ~|disable_i[k:0];
    end
    for (k = 0; k < 4; k++) begin : g_par
      assign ind_en[k] = ~|disable_i[k:0];
      assign ind_en[k+4] = ~|disable_i[k+4:4];
      assign par_en[k] = ind_en[k] & ind_en[k+4];
      assign par_en[k+4] = ind_en[k] & ind_en[k+4];
    end
  endgenerate
  always_comb begin
    if (!parallel_i) begin
      enable_o = seq_en;
    end else if (paired_i) begin
      enable_o = par_en;
    end else begin
      enable_o = ind_en;
    end
  end
endmodule

// [verilog/adcsf_sticky.sv]
`timescale 1ns/10ps
module adcsf_sticky
  import adcsf_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // events
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flag_o
);
  logic [W-1:0] flag_ff;
  // set beats a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= (flag_ff & ~clr_i) | set_i;
    end
  end
  assign flag_o = flag_ff;
endmodule

// [verilog/adcsf_top.sv]
`timescale 1ns/10ps
module adcsf_top
  import adcsf_pkg::*;
#(
  parameter int AW = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scan sequencer
  input wire adcsf_scan_t scan_a_i,
  input wire adcsf_scan_t scan_b_i,
  output logic start_grant_a_o,
  output logic start_grant_b_o,
  output logic [7:0] slot_enable_o,
  // conversion core
  input wire adcsf_conv_t conv_i,
  input wire logic [7:0] result_read_i,
  // interrupt requests
  output logic irq_done_o,
  output logic irq_zc_o,
  output logic irq_under_o,
  output logic irq_over_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [4:0] ctrl_ff;
  logic [15:0] zsel_ff;
  logic [7:0] disable_ff, prev_sign_ff, slot_en_ff, mask;
  logic act_a_ff, act_b_ff, grant_a_ff, grant_b_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic irq_done_ff, irq_zc_ff, irq_under_ff, irq_over_ff;
  logic [7:0] ready_flags, under_flags, over_flags, zc_flags;
  logic [1:0] done_flags;
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [21:0] idx;
  logic setup, wr, hit, indep;
  logic [7:0] slot_hot;
  logic [1:0] zsel_cur, done_set, done_clr;
  logic sign_now, sign_old, under_hit, over_hit, zc_hit;
  logic [7:0] under_set, over_set, zc_set;
  logic [7:0] under_clr, over_clr, zc_clr;
  logic [15:0] status_word;
  logic [31:0] rd_mux;

  assign idx = paddr[AW-1:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready_ff;
  assign hit = (idx == CTRL_IDX) || (idx == ZSEL_IDX) ||
               (idx == SAMPLE_SLOT_DISABLE_IDX) || (idx == STATUS_IDX) ||
               (idx == BOUND_IDX) || (idx == ZSTS_IDX);
  assign indep = ctrl_ff[CTRL_PAR] && !ctrl_ff[CTRL_PAIRED];

  assign status_word = {act_a_ff, act_b_ff, 1'b0, done_flags[1],
                        done_flags[0], |zc_flags, |under_flags,
                        |over_flags, ready_flags};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      CTRL_IDX: rd_mux[4:0] = ctrl_ff;
      ZSEL_IDX: rd_mux[15:0] = zsel_ff;
      SAMPLE_SLOT_DISABLE_IDX: rd_mux[7:0] = disable_ff;
      STATUS_IDX: rd_mux[15:0] = status_word;
      BOUND_IDX: rd_mux[15:0] = {over_flags, under_flags};
      ZSTS_IDX: rd_mux[7:0] = zc_flags;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait-free access: answer prepared during setup
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !hit;
      prdata_ff <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // all slots enabled after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disable_ff <= SAMPLE_SLOT_DISABLE_RST;
    end else if (wr && idx == SAMPLE_SLOT_DISABLE_IDX) begin
      disable_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      zsel_ff <= ZSEL_RST;
    end else begin
      if (wr && idx == CTRL_IDX) begin
        ctrl_ff <= pwdata[4:0];
      end
      if (wr && idx == ZSEL_IDX) begin
        zsel_ff <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // slot gating
  // ----------------------------------------
  adcsf_slot_mask u_mask (
    .disable_i(disable_ff),
    .parallel_i(ctrl_ff[CTRL_PAR]),
    .paired_i(ctrl_ff[CTRL_PAIRED]),
    .enable_o(mask)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_en_ff <= 8'hff;
    end else begin
      slot_en_ff <= mask;
    end
  end
  assign slot_enable_o = slot_en_ff;

  // ----------------------------------------
  // scan activity
  // ----------------------------------------
  // starts only honoured while idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_a_ff <= 1'b0;
      grant_a_ff <= 1'b0;
    end else begin
      grant_a_ff <= scan_a_i.start && !act_a_ff;
      if (scan_a_i.start && !act_a_ff) begin
        act_a_ff <= 1'b1;
      end else if (scan_a_i.idle) begin
        act_a_ff <= 1'b0;
      end
    end
  end

  // converter b runs on its own only in independent mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_b_ff <= 1'b0;
      grant_b_ff <= 1'b0;
    end else begin
      grant_b_ff <= indep && scan_b_i.start && !act_b_ff;
      if (indep && scan_b_i.start && !act_b_ff) begin
        act_b_ff <= 1'b1;
      end else if (scan_b_i.idle || !indep) begin
        act_b_ff <= 1'b0;
      end
    end
  end
  assign start_grant_a_o = grant_a_ff;
  assign start_grant_b_o = grant_b_ff;

  // ----------------------------------------
  // end of scan flags
  // ----------------------------------------
  // every iteration sets the flag
  assign done_set = {indep && scan_b_i.iter_done, scan_a_i.iter_done};
  assign done_clr = (wr && idx == STATUS_IDX) ?
                    pwdata[ST_DONE_B:ST_DONE_A] : 2'b00;

  adcsf_sticky #(.W(2)) u_done (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(done_set),
    .clr_i(done_clr),
    .flag_o(done_flags)
  );

  // ----------------------------------------
  // per conversion checks
  // ----------------------------------------
  assign slot_hot = conv_i.valid ? (8'h01 << conv_i.slot) : 8'h00;
  assign zsel_cur = {zsel_ff[{conv_i.slot, 1'b1}],
                     zsel_ff[{conv_i.slot, 1'b0}]};
  assign sign_now = conv_i.corrected[15];
  assign sign_old = prev_sign_ff[conv_i.slot];

  assign under_hit = (conv_i.floor != FLOOR_OFF) &&
                     ($signed(conv_i.raw) < $signed(conv_i.floor));
  assign over_hit = (conv_i.ceiling != CEIL_OFF) &&
                    ($signed(conv_i.raw) > $signed(conv_i.ceiling));

  always_comb begin
    case (zsel_cur)
      ZSEL_POS_NEG: zc_hit = !sign_old && sign_now;
      ZSEL_NEG_POS: zc_hit = sign_old && !sign_now;
      ZSEL_ANY: zc_hit = sign_old != sign_now;
      default: zc_hit = 1'b0;
    endcase
  end

  // sign history kept even while detection is off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_sign_ff <= 8'h00;
    end else if (conv_i.valid) begin
      prev_sign_ff[conv_i.slot] <= sign_now;
    end
  end

  assign under_set = under_hit ? slot_hot : 8'h00;
  assign over_set = over_hit ? slot_hot : 8'h00;
  assign zc_set = zc_hit ? slot_hot : 8'h00;
  // write one to clear single bits
  assign under_clr = (wr && idx == BOUND_IDX) ? pwdata[7:0] : 8'h00;
  assign over_clr = (wr && idx == BOUND_IDX) ? pwdata[15:8] : 8'h00;
  assign zc_clr = (wr && idx == ZSTS_IDX) ? pwdata[7:0] : 8'h00;

  // summaries are the or of slot bits
  adcsf_sticky #(.W(8)) u_under (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(under_set),
    .clr_i(under_clr),
    .flag_o(under_flags)
  );

  adcsf_sticky #(.W(8)) u_over (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(over_set),
    .clr_i(over_clr),
    .flag_o(over_flags)
  );

  adcsf_sticky #(.W(8)) u_zc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(zc_set),
    .clr_i(zc_clr),
    .flag_o(zc_flags)
  );

  // ready sets on store, read clears
  adcsf_sticky #(.W(8)) u_ready (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(slot_hot),
    .clr_i(result_read_i),
    .flag_o(ready_flags)
  );

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  // flag and enable, one cycle late; done request has no enable, follows done flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_done_ff <= 1'b0;
      irq_zc_ff <= 1'b0;
      irq_under_ff <= 1'b0;
      irq_over_ff <= 1'b0;
    end else begin
      irq_done_ff <= |done_flags;
      irq_zc_ff <= (|zc_flags) && ctrl_ff[CTRL_ZIE];
      irq_under_ff <= (|under_flags) && ctrl_ff[CTRL_UIE];
      irq_over_ff <= (|over_flags) && ctrl_ff[CTRL_OIE];
    end
  end
  assign irq_done_o = irq_done_ff;
  assign irq_zc_o = irq_zc_ff;
  assign irq_under_o = irq_under_ff;
  assign irq_over_o = irq_over_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence start_busy_s;
    act_a_ff && scan_a_i.start && !scan_a_i.idle;
  endsequence
  sequence done_pending_s;
    done_flags[0] && !scan_a_i.iter_done;
  endsequence
  sample_slot_disable_hold_a: assert property (
    !(wr && idx == SAMPLE_SLOT_DISABLE_IDX) |=> $stable(disable_ff))
    else $error("slot disable changed without a write");
  seq_stop_a: assert property (
    (!ctrl_ff[CTRL_PAR] && disable_ff == 8'h20) |=>
      slot_enable_o == 8'h1f)
    else $error("sequential scan not stopped before slot five");
  later_off_a: assert property (
    (!ctrl_ff[CTRL_PAR] && disable_ff[0]) |=> slot_enable_o == 8'h00)
    else $error("later slots stay enabled");
  paired_mask_a: assert property (
    (ctrl_ff[CTRL_PAR] && ctrl_ff[CTRL_PAIRED] &&
     (disable_ff == 8'h02 || disable_ff == 8'h20)) |=>
      slot_enable_o == 8'h11)
    else $error("paired scan does not reduce to slots zero and four");
  reserved_zero_a: assert property (
    (setup && !pwrite && idx == STATUS_IDX) |=>
      prdata[31:16] == 16'h0000 && !prdata[13])
    else $error("reserved status bits read nonzero");
  start_ignored_a: assert property (
    start_busy_s |=> !start_grant_a_o ##0 act_a_ff)
    else $error("start honoured during an active scan");
  done_set_a: assert property (
    scan_a_i.iter_done |=> status_word[ST_DONE_A])
    else $error("done flag a missing after iteration");
  done_sticky_a: assert property (
    (done_pending_s ##0 !(wr && idx == STATUS_IDX &&
      pwdata[ST_DONE_A])) |=> done_flags[0])
    else $error("done flag a lost without a clear");
  floor_off_a: assert property (
    (conv_i.valid && conv_i.floor == FLOOR_OFF && under_flags == 8'h00)
      |=> under_flags == 8'h00)
    else $error("disabled floor raised a flag");
  ceil_off_a: assert property (
    (conv_i.valid && conv_i.ceiling == CEIL_OFF && over_flags == 8'h00)
      |=> over_flags == 8'h00)
    else $error("disabled ceiling raised a flag");
  zc_disabled_a: assert property (
    (conv_i.valid && zsel_cur == 2'h0 && zc_flags == 8'h00 &&
     !(wr && idx == ZSTS_IDX)) |=> zc_flags == 8'h00)
    else $error("disabled slot set its sign change bit");
  ready_clear_a: assert property (
    (result_read_i[0] && !slot_hot[0]) |=> !ready_flags[0])
    else $error("ready bit zero survived a result read");
  irq_follow_a: assert property (
    ((|over_flags) && ctrl_ff[CTRL_OIE]) |=> irq_over_o)
    else $error("over ceiling request not raised");
endmodule
